// [include/mclcr_consts.vh]
// Constants for the closed-loop configuration register bank.
// Assumes inclusion by bare name from files under verilog/.
`ifndef MCLCR_CONSTS_VH
`define MCLCR_CONSTS_VH

// Register word indices; the byte address on the bus is four times the index
`define MCLCR_IDX_STOP_CFG     8'h8a
`define MCLCR_IDX_FB_CFG       8'h88
`define MCLCR_ADDR_STOP_CFG    10'h228
`define MCLCR_ADDR_FB_CFG      10'h220
// Feedback register fields
`define MCLCR_FB_DIV_MSB       11
`define MCLCR_FB_DIV_LSB       8
`define MCLCR_FB_GATE_BIT      7
`define MCLCR_FB_THR_MSB       6
`define MCLCR_FB_THR_LSB       4
`define MCLCR_FB_SURGE_BIT     3
`define MCLCR_FB_DTC_BIT       2
`define MCLCR_FB_VLDIS_BIT     1
`define MCLCR_FB_SLOWBRK_BIT   0
`define MCLCR_FB_MASK          32'h00000fff
// Stop register fields
`define MCLCR_ST_METHOD_MSB    30
`define MCLCR_ST_METHOD_LSB    28
`define MCLCR_ST_BRK_MSB       27
`define MCLCR_ST_BRK_LSB       24
`define MCLCR_ST_SPIN_MSB      23
`define MCLCR_ST_SPIN_LSB      20
`define MCLCR_ST_BSPD_MSB      19
`define MCLCR_ST_BSPD_LSB      16
`define MCLCR_ST_RES_MSB       15
`define MCLCR_ST_RES_LSB       8
`define MCLCR_ST_IND_MSB       7
`define MCLCR_ST_IND_LSB       0
`define MCLCR_ST_MASK          32'h7fffffff
// Reset values
`define MCLCR_FB_RESET         32'h00000000
`define MCLCR_ST_RESET         32'h00000000
// Stop method codes
`define MCLCR_STOP_HIZ         3'h0
`define MCLCR_STOP_LOWSIDE     3'h2
`define MCLCR_STOP_HIGHSIDE    3'h3
`define MCLCR_STOP_SPINDOWN    3'h4
`define MCLCR_STOP_ALIGN       3'h5
// Timing
`define MCLCR_CLK_MHZ          200
`define MCLCR_BRK_MS_MIN       1
`define MCLCR_CYC_PER_MS       (`MCLCR_CLK_MHZ * 1000)
// AXI responses
`define MCLCR_RESP_OKAY        2'h0
`define MCLCR_RESP_SLVERR      2'h2

`endif

// [verilog/mclcr_pulse_div.v]
// Speed-feedback pulse divider: passes one output edge pair per N input pulses.
// Assumes the raw pulse input is synchronous to sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
module mclcr_pulse_div #(
  parameter W = 4
) (
  input  wire         sys_clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] div_i,
  input  wire         pulse_i,
  output reg          pulse_o
);
  reg         pulse_d;
  reg [W-1:0] cnt;
  wire        flip = pulse_i ^ pulse_d;
  // Codes 0 and 1 both divide by one
  wire [W-1:0] last = (div_i < {{(W-1){1'b0}}, 1'b1}) ? {W{1'b0}} : div_i - 1'b1;

  // Toggle output every N input edges, both kinds counted, so one output period spans
  // N input periods; counting rising edges only would divide by 2N instead
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pulse_d <= 1'b0;
      cnt     <= {W{1'b0}};
      pulse_o <= 1'b0;
    end else begin
      pulse_d <= pulse_i;
      if (div_i <= {{(W-1){1'b0}}, 1'b1}) begin
        pulse_o <= pulse_i;
        cnt     <= {W{1'b0}};
      end else if (flip) begin
        if (cnt >= last) begin
          cnt     <= {W{1'b0}};
          pulse_o <= ~pulse_o;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [verilog/mclcr_regs.v]
// Closed-loop configuration register bank with AXI4-Lite slave and decoded controls.
// Assumes one clock, AXI master synchronous to sys_clk_i, raw pulse and back-EMF inputs.
// Summary of operation
// - Feedback pulse divided by 4-bit code; codes 0 and 1 divide by one.
// - Gating bit 0: pulses while driven; 1: only until back-EMF below threshold.
// - 3-bit threshold picks 1,2,5,10,20,30 mV; codes 6,7 reserved.
// - Surge protection enabled only when its bit is 1.
// - Deadtime compensation applied only while its bit is 1.
// - Speed loop runs when disable bit is 0, bypassed when 1.
// - Recirculation stop in align/open loop: bit 0 hi-Z, bit 1 low-side brake.
// - 3-bit stop method: 0 hi-Z, 2 low, 3 high, 4 spin down, 5 align.
// - 4-bit brake time: codes 0-4 1 ms, then 5 up to 15000 ms.
// - 4-bit spin-down threshold, percent of maximum speed, 100 down to 2.5.
// - 4-bit brake speed threshold, same percent encoding, for brake pin and methods.
// - 8-bit phase resistance code passed to the resistance lookup.
// - 8-bit phase inductance code passed to the inductance lookup.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "mclcr_consts.vh"
module mclcr_regs #(
  parameter BRK_UNIT_CYC = `MCLCR_CYC_PER_MS
) (
  input  wire        sys_clk_i,
  input  wire        rst_i,
  // AXI4-Lite slave
  input  wire [9:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [9:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Motor control side
  input  wire        motor_driven_i,
  input  wire        align_or_open_loop_i,
  input  wire        stop_request_i,
  input  wire        raw_speed_pulse_i,
  input  wire [15:0] back_emf_mv_i,
  output wire        speed_pulse_output_o,
  output reg  [15:0] backemf_threshold_mv_o,
  output reg         surge_protect_enable_o,
  output reg         deadtime_comp_enable_o,
  output reg         velocity_loop_run_o,
  output reg  [2:0]  stop_method_o,
  output reg         stop_method_valid_o,
  output reg         stop_hiz_o,
  output reg         stop_lowside_o,
  output reg         stop_highside_o,
  output reg         stop_spindown_o,
  output reg         stop_align_o,
  output reg  [13:0] brake_time_ms_o,
  output reg         braking_o,
  output reg  [9:0]  spin_down_pct_x10_o,
  output reg  [9:0]  brake_speed_pct_x10_o,
  output reg  [7:0]  phase_resistance_code_o,
  output reg  [7:0]  phase_inductance_code_o
);
  // Brake sequencer states, one-hot
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_BRK  = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  reg  [31:0] speed_feedback_and_loop_config;
  reg  [31:0] stop_and_motor_params_config;
  reg  [2:0]  brk_state;
  reg  [31:0] unit_cnt;
  reg  [13:0] ms_cnt;
  reg  [13:0] next_brake_ms;
  reg  [15:0] next_thr_mv;
  reg  [9:0]  next_spin;
  reg  [9:0]  next_bspd;
  reg         speed_pulse_ungated;
  wire [31:0] wmask;
  wire        wr_go;
  wire        rd_go;
  wire        wr_fb;
  wire        wr_st;

  // Field views
  wire [3:0] speed_pulse_divider    =
             speed_feedback_and_loop_config[`MCLCR_FB_DIV_MSB:`MCLCR_FB_DIV_LSB];
  wire       speed_pulse_gating_cfg = speed_feedback_and_loop_config[`MCLCR_FB_GATE_BIT];
  wire [2:0] speed_pulse_backemf_threshold =
             speed_feedback_and_loop_config[`MCLCR_FB_THR_MSB:`MCLCR_FB_THR_LSB];
  wire       velocity_loop_disable  = speed_feedback_and_loop_config[`MCLCR_FB_VLDIS_BIT];
  wire       slow_recirculation_brake_select =
             speed_feedback_and_loop_config[`MCLCR_FB_SLOWBRK_BIT];
  wire [2:0] stop_method = stop_and_motor_params_config[`MCLCR_ST_METHOD_MSB:`MCLCR_ST_METHOD_LSB];
  wire [3:0] stop_brake_duration =
             stop_and_motor_params_config[`MCLCR_ST_BRK_MSB:`MCLCR_ST_BRK_LSB];
  wire [3:0] spin_down_speed_threshold =
             stop_and_motor_params_config[`MCLCR_ST_SPIN_MSB:`MCLCR_ST_SPIN_LSB];
  wire [3:0] brake_speed_threshold =
             stop_and_motor_params_config[`MCLCR_ST_BSPD_MSB:`MCLCR_ST_BSPD_LSB];

  // Write is taken only when address, data and a free response slot are all present,
  // so the ready signals rise together; the master may present them in either order
  assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign rd_go         = s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_arready = rd_go;
  assign wr_fb = wr_go && (s_axi_awaddr[9:2] == `MCLCR_IDX_FB_CFG);
  assign wr_st = wr_go && (s_axi_awaddr[9:2] == `MCLCR_IDX_STOP_CFG);

  // Byte-lane mask from the strobes, one lane per generate step
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      assign wmask[8*g+7:8*g] = {8{s_axi_wstrb[g]}};
    end
  endgenerate

  // Register storage and write response
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      speed_feedback_and_loop_config <= `MCLCR_FB_RESET;
      stop_and_motor_params_config   <= `MCLCR_ST_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `MCLCR_RESP_OKAY;
    end else begin
      if (wr_fb) begin
        speed_feedback_and_loop_config <= ((speed_feedback_and_loop_config & ~wmask) |
                                           (s_axi_wdata & wmask)) & `MCLCR_FB_MASK;
      end
      if (wr_st) begin
        stop_and_motor_params_config <= ((stop_and_motor_params_config & ~wmask) |
                                         (s_axi_wdata & wmask)) & `MCLCR_ST_MASK;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_fb | wr_st) ? `MCLCR_RESP_OKAY : `MCLCR_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read path; reads have no side effects
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `MCLCR_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `MCLCR_RESP_OKAY;
      if (s_axi_araddr[9:2] == `MCLCR_IDX_FB_CFG) begin
        s_axi_rdata <= speed_feedback_and_loop_config;
      end else if (s_axi_araddr[9:2] == `MCLCR_IDX_STOP_CFG) begin
        s_axi_rdata <= stop_and_motor_params_config;
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `MCLCR_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Code-to-value lookups
  always @* begin
    case (speed_pulse_backemf_threshold)
      3'h0:    next_thr_mv = 16'h0001;
      3'h1:    next_thr_mv = 16'h0002;
      3'h2:    next_thr_mv = 16'h0005;
      3'h3:    next_thr_mv = 16'h000a;
      3'h4:    next_thr_mv = 16'h0014;
      3'h5:    next_thr_mv = 16'h001e;
      default: next_thr_mv = 16'h0001; // Reserved codes fall back to the smallest
    endcase
    case (stop_brake_duration)
      4'h5:    next_brake_ms = 14'h0005;
      4'h6:    next_brake_ms = 14'h000a;
      4'h7:    next_brake_ms = 14'h0032;
      4'h8:    next_brake_ms = 14'h0064;
      4'h9:    next_brake_ms = 14'h00fa;
      4'ha:    next_brake_ms = 14'h01f4;
      4'hb:    next_brake_ms = 14'h03e8;
      4'hc:    next_brake_ms = 14'h09c4;
      4'hd:    next_brake_ms = 14'h1388;
      4'he:    next_brake_ms = 14'h2710;
      4'hf:    next_brake_ms = 14'h3a98;
      default: next_brake_ms = 14'h0001;
    endcase
    next_spin = pct_x10(spin_down_speed_threshold);
    next_bspd = pct_x10(brake_speed_threshold);
  end

  // Percent of maximum speed in tenths, shared by both thresholds
  function [9:0] pct_x10;
    input [3:0] code;
    begin
      case (code)
        4'h0:    pct_x10 = 10'h3e8;
        4'h1:    pct_x10 = 10'h384;
        4'h2:    pct_x10 = 10'h320;
        4'h3:    pct_x10 = 10'h2bc;
        4'h4:    pct_x10 = 10'h258;
        4'h5:    pct_x10 = 10'h1f4;
        4'h6:    pct_x10 = 10'h1c2;
        4'h7:    pct_x10 = 10'h190;
        4'h8:    pct_x10 = 10'h15e;
        4'h9:    pct_x10 = 10'h12c;
        4'ha:    pct_x10 = 10'h0fa;
        4'hb:    pct_x10 = 10'h0c8;
        4'hc:    pct_x10 = 10'h096;
        4'hd:    pct_x10 = 10'h064;
        4'he:    pct_x10 = 10'h032;
        default: pct_x10 = 10'h019;
      endcase
    end
  endfunction

  // Registered control outputs
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      backemf_threshold_mv_o  <= 16'h0001;
      surge_protect_enable_o  <= 1'b0;
      deadtime_comp_enable_o  <= 1'b0;
      velocity_loop_run_o     <= 1'b1;
      stop_method_o           <= `MCLCR_STOP_HIZ;
      stop_method_valid_o     <= 1'b1;
      stop_hiz_o              <= 1'b1;
      stop_lowside_o          <= 1'b0;
      stop_highside_o         <= 1'b0;
      stop_spindown_o         <= 1'b0;
      stop_align_o            <= 1'b0;
      brake_time_ms_o         <= 14'h0001;
      spin_down_pct_x10_o     <= 10'h3e8;
      brake_speed_pct_x10_o   <= 10'h3e8;
      phase_resistance_code_o <= 8'h00;
      phase_inductance_code_o <= 8'h00;
      speed_pulse_ungated     <= 1'b0;
    end else begin
      backemf_threshold_mv_o <= next_thr_mv;
      surge_protect_enable_o <= speed_feedback_and_loop_config[`MCLCR_FB_SURGE_BIT];
      deadtime_comp_enable_o <= speed_feedback_and_loop_config[`MCLCR_FB_DTC_BIT];
      velocity_loop_run_o    <= ~velocity_loop_disable;
      stop_method_o          <= stop_method;
      stop_method_valid_o    <= (stop_method == `MCLCR_STOP_HIZ) ||
                                (stop_method >= `MCLCR_STOP_LOWSIDE &&
                                 stop_method <= `MCLCR_STOP_ALIGN);
      // In align or open loop a recirculating stop uses the slow-speed choice
      if (align_or_open_loop_i && (stop_method == `MCLCR_STOP_LOWSIDE ||
                                   stop_method == `MCLCR_STOP_HIGHSIDE)) begin
        stop_hiz_o      <= ~slow_recirculation_brake_select;
        stop_lowside_o  <= slow_recirculation_brake_select;
        stop_highside_o <= 1'b0;
      end else begin
        stop_hiz_o      <= (stop_method == `MCLCR_STOP_HIZ);
        stop_lowside_o  <= (stop_method == `MCLCR_STOP_LOWSIDE);
        stop_highside_o <= (stop_method == `MCLCR_STOP_HIGHSIDE);
      end
      stop_spindown_o         <= (stop_method == `MCLCR_STOP_SPINDOWN);
      stop_align_o            <= (stop_method == `MCLCR_STOP_ALIGN);
      brake_time_ms_o         <= next_brake_ms;
      spin_down_pct_x10_o     <= next_spin;
      brake_speed_pct_x10_o   <= next_bspd;
      phase_resistance_code_o <=
        stop_and_motor_params_config[`MCLCR_ST_RES_MSB:`MCLCR_ST_RES_LSB];
      phase_inductance_code_o <=
        stop_and_motor_params_config[`MCLCR_ST_IND_MSB:`MCLCR_ST_IND_LSB];
      // Gate the pulse source before division so partial periods do not leak out
      speed_pulse_ungated <= raw_speed_pulse_i &
                             (speed_pulse_gating_cfg ? (back_emf_mv_i >= next_thr_mv)
                                                     : motor_driven_i);
    end
  end

  // Brake-duration sequencer: braking_o holds for the selected time after a stop request while the low-side, high-side or align stop is decoded
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      brk_state <= ST_IDLE;
      unit_cnt  <= 32'h00000000;
      ms_cnt    <= 14'h0000;
      braking_o <= 1'b0;
    end else begin
      case (brk_state)
        ST_IDLE: begin
          if (stop_request_i && (stop_lowside_o | stop_highside_o | stop_align_o)) begin
            brk_state <= ST_BRK;
            unit_cnt  <= 32'h00000000;
            ms_cnt    <= 14'h0000;
            braking_o <= 1'b1;
          end
        end
        ST_BRK: begin
          if (unit_cnt == BRK_UNIT_CYC - 1) begin
            unit_cnt <= 32'h00000000;
            if (ms_cnt + 14'h0001 >= brake_time_ms_o) begin
              brk_state <= ST_DONE;
              braking_o <= 1'b0;
            end else begin
              ms_cnt <= ms_cnt + 14'h0001;
            end
          end else begin
            unit_cnt <= unit_cnt + 32'h00000001;
          end
        end
        ST_DONE: begin
          if (!stop_request_i) begin
            brk_state <= ST_IDLE;
          end
        end
        default: brk_state <= ST_IDLE;
      endcase
    end
  end

  // Divider for the feedback pulse output
  mclcr_pulse_div #(
    .W (4)
  ) u_div (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .div_i     (speed_pulse_divider),
    .pulse_i   (speed_pulse_ungated),
    .pulse_o   (speed_pulse_output_o)
  );
endmodule
`default_nettype wire

// [sim/mclcr_regs_monitor.sv]
// Checker for the closed-loop configuration register bank.
// Assumes binding into mclcr_regs; one clock, asynchronous high reset.
`timescale 1ns/1ps
`default_nettype none
`include "mclcr_consts.vh"
module mclcr_regs_monitor #(
  parameter BRK_UNIT_CYC = 10
) (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic [9:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        stop_request_i,
  input wire logic        surge_protect_enable_o,
  input wire logic        velocity_loop_run_o,
  input wire logic [2:0]  stop_method_o,
  input wire logic        stop_method_valid_o,
  input wire logic        stop_hiz_o,
  input wire logic        stop_lowside_o,
  input wire logic        stop_highside_o,
  input wire logic        stop_spindown_o,
  input wire logic        stop_align_o,
  input wire logic [13:0] brake_time_ms_o,
  input wire logic        braking_o
);
  logic [31:0] brk_cnt;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Cycles spent in the current brake; cleared between brakes
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) brk_cnt <= 32'h0;
    else brk_cnt <= braking_o ? brk_cnt + 32'h1 : 32'h0;
  end
  // A write is taken only when both halves meet with no answer pending
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence wr_fb_low;
    wr_taken ##0 (s_axi_awaddr == `MCLCR_ADDR_FB_CFG && s_axi_wstrb[0]);
  endsequence
  a_write_answer: assert property (wr_taken |=> s_axi_bvalid) else $error("no write answer");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer changed");
  a_surge_follows: assert property (wr_fb_low |-> ##2
    surge_protect_enable_o == $past(s_axi_wdata[3], 2)) else $error("surge enable wrong");
  a_loop_inverted: assert property (wr_fb_low |-> ##2
    velocity_loop_run_o != $past(s_axi_wdata[1], 2)) else $error("loop run wrong");
  a_method_valid: assert property (stop_method_valid_o ==
    (stop_method_o != 3'h1 && stop_method_o < 3'h6)) else $error("method valid wrong");
  a_decode_onehot: assert property (stop_method_valid_o == $onehot({stop_hiz_o,
    stop_lowside_o, stop_highside_o, stop_spindown_o, stop_align_o}))
    else $error("stop decode not one-hot");
  a_brake_start: assert property ($rose(stop_request_i) && !braking_o &&
    (stop_lowside_o || stop_highside_o || stop_align_o) |=> braking_o)
    else $error("brake did not start");
  a_brake_length: assert property ($fell(braking_o) |->
    brk_cnt == brake_time_ms_o * BRK_UNIT_CYC) else $error("brake length wrong");
endmodule
bind mclcr_regs mclcr_regs_monitor #(.BRK_UNIT_CYC(BRK_UNIT_CYC)) mclcr_regs_monitor_i (.*);
`default_nettype wire

// [sim/test_mclcr_regs.sv]
// Self-checking bench for the closed-loop configuration register bank.
// Assumes the design and its checker compiled alongside; one 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "mclcr_consts.vh"
module test_mclcr_regs;
  localparam BRK = 10;  // Short millisecond so a brake takes tens of cycles
  localparam FB = `MCLCR_ADDR_FB_CFG;
  localparam ST = `MCLCR_ADDR_STOP_CFG;
  logic sys_clk_i, rst_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, motor_driven_i, align_or_open_loop_i, stop_request_i, raw_speed_pulse_i;
  logic [9:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic [15:0] back_emf_mv_i;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire speed_pulse_output_o, surge_protect_enable_o, deadtime_comp_enable_o;
  wire velocity_loop_run_o, stop_method_valid_o, stop_hiz_o, stop_lowside_o;
  wire stop_highside_o, stop_spindown_o, stop_align_o, braking_o;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] backemf_threshold_mv_o;
  wire [2:0] stop_method_o;
  wire [13:0] brake_time_ms_o;
  wire [9:0] spin_down_pct_x10_o, brake_speed_pct_x10_o;
  wire [7:0] phase_resistance_code_o, phase_inductance_code_o;
  int n_fail = 0;
  int tests_run = 0;
  mclcr_regs #(.BRK_UNIT_CYC(BRK)) mclcr_regs_i (.*);
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    @(posedge sys_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge sys_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask
  // Decoded outputs trail the register by one more cycle
  task automatic settle;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic t_reset;
    rd(FB, 32'h0, `MCLCR_RESP_OKAY);
    rd(ST, 32'h0, `MCLCR_RESP_OKAY);
    chk({velocity_loop_run_o, stop_method_valid_o, stop_hiz_o}, 3'h7);
    chk(backemf_threshold_mv_o, 16'h1);
    chk(brake_time_ms_o, 14'h1);
    chk({spin_down_pct_x10_o, brake_speed_pct_x10_o}, {10'h3e8, 10'h3e8});
  endtask
  task automatic t_fb_bits;
    wr(FB, 32'hfffffffe, 4'hf, `MCLCR_RESP_OKAY);
    rd(FB, 32'h00000ffe, `MCLCR_RESP_OKAY);
    settle;
    chk({surge_protect_enable_o, deadtime_comp_enable_o, velocity_loop_run_o}, 3'h6);
    wr(FB, 32'h0, 4'h2, `MCLCR_RESP_OKAY);
    rd(FB, 32'h000000fe, `MCLCR_RESP_OKAY);
    wr(FB, 32'h0, 4'hf, `MCLCR_RESP_OKAY);
    settle;
    chk({surge_protect_enable_o, deadtime_comp_enable_o, velocity_loop_run_o}, 3'h1);
    wr(10'h3fc, 32'hffffffff, 4'hf, `MCLCR_RESP_SLVERR);
    rd(10'h3fc, 32'h0, `MCLCR_RESP_SLVERR);
    rd(FB, 32'h0, `MCLCR_RESP_OKAY);
  endtask
  task automatic t_threshold;
    logic [15:0] mv [8] = '{16'h1, 16'h2, 16'h5, 16'ha, 16'h14, 16'h1e, 16'h1, 16'h1};
    for (int i = 0; i < 8; i++) begin
      wr(FB, {25'h0, i[2:0], 4'h0}, 4'hf, `MCLCR_RESP_OKAY);
      settle;
      chk(backemf_threshold_mv_o, mv[i]);
    end
  endtask
  task automatic t_stop_codes;
    logic [5:0] ex [8] = '{6'h30, 6'h00, 6'h28, 6'h24, 6'h22, 6'h21, 6'h00, 6'h00};
    for (int i = 0; i < 8; i++) begin
      wr(ST, {1'b0, i[2:0], 28'h0}, 4'hf, `MCLCR_RESP_OKAY);
      settle;
      chk({stop_method_valid_o, stop_hiz_o, stop_lowside_o, stop_highside_o,
           stop_spindown_o, stop_align_o, stop_method_o}, {ex[i], i[2:0]});
    end
  endtask
  task automatic t_stop_fields;
    logic [13:0] ms [16] = '{14'h1, 14'h1, 14'h1, 14'h1, 14'h1, 14'h5, 14'ha, 14'h32,
      14'h64, 14'hfa, 14'h1f4, 14'h3e8, 14'h9c4, 14'h1388, 14'h2710, 14'h3a98};
    logic [9:0] pc [16] = '{10'h3e8, 10'h384, 10'h320, 10'h2bc, 10'h258, 10'h1f4, 10'h1c2,
      10'h190, 10'h15e, 10'h12c, 10'hfa, 10'hc8, 10'h96, 10'h64, 10'h32, 10'h19};
    logic [31:0] w;
    for (int i = 0; i < 16; i++) begin
      w = {4'h2, i[3:0], i[3:0], ~i[3:0], i[3:0], ~i[3:0], ~i[3:0], i[3:0]};
      wr(ST, w | 32'h80000000, 4'hf, `MCLCR_RESP_OKAY);
      rd(ST, w, `MCLCR_RESP_OKAY);
      settle;
      chk(brake_time_ms_o, ms[i]);
      chk({spin_down_pct_x10_o, brake_speed_pct_x10_o}, {pc[i], pc[15-i]});
      chk({phase_resistance_code_o, phase_inductance_code_o}, w[15:0]);
    end
  endtask
  task automatic t_recirc;
    align_or_open_loop_i <= 1'b1;
    wr(ST, 32'h20000000, 4'hf, `MCLCR_RESP_OKAY);
    wr(FB, 32'h0, 4'hf, `MCLCR_RESP_OKAY);
    settle;
    chk({stop_hiz_o, stop_lowside_o, stop_highside_o}, 3'h4);
    wr(FB, 32'h1, 4'hf, `MCLCR_RESP_OKAY);
    wr(ST, 32'h30000000, 4'hf, `MCLCR_RESP_OKAY);
    settle;
    chk({stop_hiz_o, stop_lowside_o, stop_highside_o}, 3'h2);
    align_or_open_loop_i <= 1'b0;
    settle;
    chk({stop_hiz_o, stop_lowside_o, stop_highside_o}, 3'h1);
  endtask
  // Low-side stop with a 5 ms brake, then released so the brake rearms
  task automatic t_brake;
    int m;
    m = 0;
    wr(ST, 32'h25000000, 4'hf, `MCLCR_RESP_OKAY);
    settle;
    @(posedge sys_clk_i);
    stop_request_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    chk(braking_o, 1'b1);
    while (braking_o === 1'b1 && m < 300) begin
      @(posedge sys_clk_i);
      m++;
    end
    chk(m, 5 * BRK);
    stop_request_i <= 1'b0;
  endtask
  // Sends np pulses of four cycles and counts output level changes
  task automatic pulses(input int np, input int et);
    int t;
    logic last;
    t = 0;
    last = speed_pulse_output_o;
    for (int k = 0; k < np * 4 + 8; k++) begin
      @(posedge sys_clk_i);
      raw_speed_pulse_i <= (k < np * 4) && (k % 4 < 2);
      if (speed_pulse_output_o !== last) t++;
      last = speed_pulse_output_o;
    end
    chk(t, et);
  endtask
  task automatic t_pulse;
    logic [3:0] dv [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'hf};
    int et [6] = '{60, 60, 30, 20, 12, 4};
    motor_driven_i <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      wr(FB, {20'h0, dv[i], 8'h0}, 4'hf, `MCLCR_RESP_OKAY);
      pulses(30, et[i]);
    end
    wr(FB, 32'h80, 4'hf, `MCLCR_RESP_OKAY);
    pulses(30, 0);
    back_emf_mv_i <= 16'h5;
    pulses(30, 60);
    wr(FB, 32'h0, 4'hf, `MCLCR_RESP_OKAY);
    motor_driven_i <= 1'b0;
    pulses(30, 0);
  endtask
  // Run takes well under 10000 cycles; twice that means a hang
  initial begin
    #100000;
    n_fail++;
    give_verdict;
  end
  initial begin
    {rst_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
    {motor_driven_i, align_or_open_loop_i, stop_request_i, raw_speed_pulse_i} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 56'h0;
    back_emf_mv_i = 16'h0;
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_fb_bits;
    t_threshold;
    t_stop_codes;
    t_stop_fields;
    t_recirc;
    t_brake;
    t_pulse;
    give_verdict;
  end
endmodule
`default_nettype wire
